// File: hdl/electrode_lead_off_monitor.sv
`include "leadoff_defines.svh"

// Function
// - Two dual DC comparators check sense voltage
// - DC detection runs only when enabled
// - Three-bit field selects DC injection current
// - Either input crossing upper/lower limit flags
// - Four-bit field sets DC comparator threshold
// - DC flag after 115 or 140 ms
// - Drive sample outside window trips checker
// - Drive checking active only when enabled
// - Drive flag after 125 or 128 ms
// - AC checker compares ADC output, enabled
// - AC lower and upper limit registers
// - Over/under flags after 128 ms persistence
// - Status flags clear when read
module electrode_lead_off_monitor #(
    parameter int DC_FAST_CYC  = `MS_TO_CYC(`T_DC_FAST_MS),
    parameter int DC_SLOW_CYC  = `MS_TO_CYC(`T_DC_SLOW_MS),
    parameter int DRV_FAST_CYC = `MS_TO_CYC(`T_DRV_FAST_MS),
    parameter int DRV_SLOW_CYC = `MS_TO_CYC(`T_DRV_SLOW_MS),
    parameter int AC_CYC       = `MS_TO_CYC(`T_AC_MS)
) (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // Analog comparator results and receive ADC samples
    input  wire leadoff_pkg::cmp_pins_t cmp_pins,
    input  wire leadoff_pkg::adc_word_t adc_word,
    // Settings to the analog front end
    output leadoff_pkg::cfg_t          cfg,
    // Interrupt
    output logic                       irq
);
    import leadoff_pkg::*;

    state_t      st;
    state_t      next_st;
    logic [9:0]  idx;
    logic        access;
    logic        done;
    logic [6:0]  viol;
    logic [6:0]  ev;
    logic [6:0]  clr;
    logic [6:0][22:0] lim;

    assign idx = paddr[11:2];
    assign access = psel & penable;
    assign done = access & st.pready;

    function automatic logic mapped(input logic [9:0] i);
        unique case (i)
            `IDX_STATUS, `IDX_MASK, `IDX_CLOCK, `IDX_AC_CTRL,
            `IDX_AC_LOWER, `IDX_AC_UPPER, `IDX_DC_CTRL,
            `IDX_DC_THRESH: mapped = 1'b1;
            default:        mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] read_reg(input logic [9:0] i,
                                             input state_t s);
        logic [7:0] v;
        v = 8'h00;
        unique case (i)
            `IDX_STATUS:    v = {1'b0, s.status};
            `IDX_MASK:      v = {1'b0, s.mask};
            `IDX_CLOCK:     v[`POS_CLK_SEL] = s.cfg.timing_clock_select;
            `IDX_AC_CTRL:   v[`POS_AC_EN] = s.cfg.ac_threshold_enable;
            `IDX_AC_LOWER:  v = s.cfg.ac_lower_limit;
            `IDX_AC_UPPER:  v = s.cfg.ac_upper_limit;
            `IDX_DC_CTRL: begin
                v[`POS_DC_EN]  = s.cfg.dc_leadoff_enable;
                v[`POS_EXT_EN] = s.cfg.external_leadoff_enable;
                v[`POS_DRV_EN] = s.cfg.drive_range_check_enable;
                v[2:0]         = s.cfg.dc_leadoff_current_sel;
            end
            `IDX_DC_THRESH: v[3:0] = s.cfg.dc_leadoff_threshold;
            default:        v = 8'h00;
        endcase
        read_reg = {24'h000000, v};
    endfunction

    // Persistence length per timer; bits 3:0 DC, 4 drive, 5/6 AC
    function automatic logic [22:0] limit_for(input int i,
                                              input logic fast);
        if (i < 4) begin
            limit_for = fast ? 23'(DC_FAST_CYC) : 23'(DC_SLOW_CYC);
        end else if (i == 4) begin
            limit_for = fast ? 23'(DRV_FAST_CYC) : 23'(DRV_SLOW_CYC);
        end else begin
            limit_for = 23'(AC_CYC);
        end
    endfunction

    always_comb begin
        next_st = st;
        ev = 7'h00;
        clr = 7'h00;

        // Three-flop synchronisers; a change counts when stages 2 and 3 agree
        next_st.sync1 = {cmp_pins.dc, cmp_pins.drv_low, cmp_pins.drv_high};
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        for (int i = 0; i < 6; i++) begin
            if (st.sync2[i] == st.sync3[i]) begin
                next_st.cmp[i] = st.sync3[i];
            end
        end

        // ADC upper byte against the limits, held between samples
        if (adc_word.valid) begin
            next_st.ac_over  = adc_word.data[19:12] >
                               st.cfg.ac_upper_limit;
            next_st.ac_under = adc_word.data[19:12] <
                               st.cfg.ac_lower_limit;
        end

        // Any of four DC comparator limits counts, gated by enable
        viol[3:0] = st.cmp[5:2] &
                    {4{st.cfg.dc_leadoff_enable}};
        viol[4] = (st.cmp[1] | st.cmp[0]) &
                  st.cfg.drive_range_check_enable;
        viol[5] = st.ac_under & st.cfg.ac_threshold_enable;
        viol[6] = st.ac_over & st.cfg.ac_threshold_enable;

        // Timers saturate, so a lasting fault sets its flag again after a read
        for (int i = 0; i < 7; i++) begin
            lim[i] = limit_for(i, st.cfg.timing_clock_select);
            if (!viol[i]) begin
                next_st.cnt[i] = 23'h000000;
            end else if (st.cnt[i] < lim[i]) begin
                next_st.cnt[i] = st.cnt[i] + 23'h000001;
            end
            ev[i] = viol[i] &&
                    (st.cnt[i] >= lim[i] - 23'h000001);
        end

        // APB: one wait state, then pready with data
        next_st.pready  = access & ~st.pready;
        next_st.pslverr = access & ~st.pready & ~mapped(idx);
        if (access && !st.pready) begin
            next_st.prdata = pwrite ? 32'h00000000 : read_reg(idx, st);
        end

        if (done && pwrite) begin
            unique case (idx)
                `IDX_STATUS:  clr = pwdata[6:0];
                `IDX_MASK:    next_st.mask = pwdata[6:0];
                `IDX_CLOCK: begin
                    next_st.cfg.timing_clock_select = pwdata[`POS_CLK_SEL];
                end
                `IDX_AC_CTRL: begin
                    next_st.cfg.ac_threshold_enable = pwdata[`POS_AC_EN];
                end
                `IDX_AC_LOWER: begin
                    next_st.cfg.ac_lower_limit = pwdata[7:0];
                end
                `IDX_AC_UPPER: begin
                    next_st.cfg.ac_upper_limit = pwdata[7:0];
                end
                `IDX_DC_CTRL: begin
                    next_st.cfg.dc_leadoff_enable = pwdata[`POS_DC_EN];
                    next_st.cfg.external_leadoff_enable =
                        pwdata[`POS_EXT_EN];
                    next_st.cfg.drive_range_check_enable =
                        pwdata[`POS_DRV_EN];
                    next_st.cfg.dc_leadoff_current_sel = pwdata[2:0];
                end
                `IDX_DC_THRESH: begin
                    next_st.cfg.dc_leadoff_threshold = pwdata[3:0];
                end
                default: clr = 7'h00;
            endcase
        end else if (done && idx == `IDX_STATUS) begin
            // Only bits that were reported get cleared, none set since
            clr = st.prdata[6:0];
        end

        // Set wins over clear
        next_st.status = (st.status & ~clr) | ev;
        next_st.irq = |(next_st.status & next_st.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.status <= `RST_STATUS;
            st.mask <= `RST_STATUS;
            st.cfg.ac_lower_limit <= `RST_REG8;
            st.cfg.ac_upper_limit <= `RST_REG8;
        end else begin
            st <= next_st;
        end
    end

    assign pready  = st.pready;
    assign prdata  = st.prdata;
    assign pslverr = st.pslverr;
    assign cfg     = st.cfg;
    assign irq     = st.irq;

    // Checks
    logic status_read_done;
    assign status_read_done = done & ~pwrite & (idx == `IDX_STATUS);

    property p_dc_gated;
        @(posedge pclk) disable iff (!presetn)
        !st.cfg.dc_leadoff_enable |=> (st.cnt[3:0] == '0);
    endproperty
    a_dc_gated: assert property (p_dc_gated)
        else $error("dc timer runs while disabled");

    property p_drv_gated;
        @(posedge pclk) disable iff (!presetn)
        !st.cfg.drive_range_check_enable |=> (st.cnt[4] == '0);
    endproperty
    a_drv_gated: assert property (p_drv_gated)
        else $error("drive timer runs while disabled");

    property p_ac_gated;
        @(posedge pclk) disable iff (!presetn)
        !st.cfg.ac_threshold_enable |=> (st.cnt[6:5] == '0);
    endproperty
    a_ac_gated: assert property (p_ac_gated)
        else $error("ac timers run while disabled");

    property p_dc_persist;
        @(posedge pclk) disable iff (!presetn)
        $rose(st.status[0]) |->
            ($past(st.cnt[0]) >= $past(lim[0]) - 23'h000001);
    endproperty
    a_dc_persist: assert property (p_dc_persist)
        else $error("dc flag set before persistence");

    property p_drv_persist;
        @(posedge pclk) disable iff (!presetn)
        $rose(st.status[`POS_DRV_FLAG]) |->
            ($past(st.cnt[4]) >= $past(lim[4]) - 23'h000001);
    endproperty
    a_drv_persist: assert property (p_drv_persist)
        else $error("drive flag set before persistence");

    property p_ac_persist;
        @(posedge pclk) disable iff (!presetn)
        $rose(st.status[`POS_AC_OVER]) |->
            ($past(st.cnt[6]) == 23'(AC_CYC) - 23'h000001 ||
             $past(st.cnt[6]) == 23'(AC_CYC));
    endproperty
    a_ac_persist: assert property (p_ac_persist)
        else $error("over flag set before persistence");

    property p_read_clears;
        @(posedge pclk) disable iff (!presetn)
        status_read_done |=>
            (st.status == (($past(st.status) & ~$past(st.prdata[6:0]))
                           | $past(ev)));
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("status not cleared by read");

    property p_restart;
        @(posedge pclk) disable iff (!presetn)
        !viol[0] ##1 !viol[0] |-> (st.cnt[0] == '0);
    endproperty
    a_restart: assert property (p_restart)
        else $error("dc timer not restarted");

    property p_cur_write;
        @(posedge pclk) disable iff (!presetn)
        (done && pwrite && idx == `IDX_DC_CTRL) |=>
            (cfg.dc_leadoff_current_sel == $past(pwdata[2:0]));
    endproperty
    a_cur_write: assert property (p_cur_write)
        else $error("current select not written");

    property p_thr_write;
        @(posedge pclk) disable iff (!presetn)
        (done && pwrite && idx == `IDX_DC_THRESH) |=>
            (cfg.dc_leadoff_threshold == $past(pwdata[3:0]));
    endproperty
    a_thr_write: assert property (p_thr_write)
        else $error("threshold not written");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        irq == |(st.status & st.mask);
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq does not follow masked status");

    property p_drv_restart;
        @(posedge pclk) disable iff (!presetn)
        !viol[4] |=> (st.cnt[4] == '0);
    endproperty
    a_drv_restart: assert property (p_drv_restart)
        else $error("drive timer not restarted");

    property p_dc_sets;
        @(posedge pclk) disable iff (!presetn)
        (viol[0] && st.cnt[0] >= lim[0] - 23'h000001) |=> st.status[0];
    endproperty
    a_dc_sets: assert property (p_dc_sets)
        else $error("dc flag missing after persistence");

    property p_drv_sets;
        @(posedge pclk) disable iff (!presetn)
        (viol[4] && st.cnt[4] >= lim[4] - 23'h000001) |=>
            st.status[`POS_DRV_FLAG];
    endproperty
    a_drv_sets: assert property (p_drv_sets)
        else $error("drive flag missing after persistence");

    property p_ac_sets;
        @(posedge pclk) disable iff (!presetn)
        (viol[6] && st.cnt[6] >= 23'(AC_CYC) - 23'h000001) |=>
            st.status[`POS_AC_OVER];
    endproperty
    a_ac_sets: assert property (p_ac_sets)
        else $error("over flag missing after persistence");

    property p_under_persist;
        @(posedge pclk) disable iff (!presetn)
        $rose(st.status[`POS_AC_UNDER]) |->
            ($past(st.cnt[5]) >= 23'(AC_CYC) - 23'h000001);
    endproperty
    a_under_persist: assert property (p_under_persist)
        else $error("under flag set before persistence");

    property p_wait_state;
        @(posedge pclk) disable iff (!presetn)
        (access && !st.pready) |=> st.pready;
    endproperty
    a_wait_state: assert property (p_wait_state)
        else $error("ready not given after one wait state");

    property p_sync_agree;
        @(posedge pclk) disable iff (!presetn)
        ((st.cmp ^ $past(st.cmp)) &
         ($past(st.sync2) ^ $past(st.sync3))) == 6'h00;
    endproperty
    a_sync_agree: assert property (p_sync_agree)
        else $error("comparator taken before stages agreed");

endmodule

// File: shared/leadoff_defines.svh
`ifndef LEADOFF_DEFINES_SVH
`define LEADOFF_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_STATUS     10'h001
`define IDX_MASK       10'h002
`define IDX_CLOCK      10'h01A
`define IDX_AC_CTRL    10'h021
`define IDX_AC_LOWER   10'h026
`define IDX_AC_UPPER   10'h027
`define IDX_DC_CTRL    10'h050
`define IDX_DC_THRESH  10'h051

// Field positions
`define POS_DC_EN      6
`define POS_EXT_EN     5
`define POS_DRV_EN     4
`define POS_CLK_SEL    5
`define POS_AC_EN      0
`define POS_AC_OVER    6
`define POS_AC_UNDER   5
`define POS_DRV_FLAG   4

// Reset values
`define RST_REG8       8'h00
`define RST_STATUS     7'h00

// Timing at a 50 MHz pclk
`define CLK_KHZ        50000
`define T_DC_FAST_MS   115
`define T_DC_SLOW_MS   140
`define T_DRV_FAST_MS  125
`define T_DRV_SLOW_MS  128
`define T_AC_MS        128
`define MS_TO_CYC(ms)  ((ms) * `CLK_KHZ)

`endif

// File: shared/leadoff_pkg.sv
package leadoff_pkg;

    typedef struct packed {
        logic [3:0] dc;        // pos high, pos low, neg high, neg low
        logic       drv_low;
        logic       drv_high;
    } cmp_pins_t;

    typedef struct packed {
        logic        valid;
        logic [19:0] data;
    } adc_word_t;

    typedef struct packed {
        logic       dc_leadoff_enable;
        logic       external_leadoff_enable;
        logic       drive_range_check_enable;
        logic [2:0] dc_leadoff_current_sel;
        logic [3:0] dc_leadoff_threshold;
        logic       timing_clock_select;
        logic       ac_threshold_enable;
        logic [7:0] ac_lower_limit;
        logic [7:0] ac_upper_limit;
    } cfg_t;

    typedef struct packed {
        cfg_t              cfg;
        logic [6:0]        status;
        logic [6:0]        mask;
        logic [5:0]        sync1;
        logic [5:0]        sync2;
        logic [5:0]        sync3;
        logic [5:0]        cmp;
        logic              ac_over;
        logic              ac_under;
        logic [6:0][22:0]  cnt;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        logic              irq;
    } state_t;

endpackage

// File: verification/lead_host_model.sv
`include "leadoff_defines.svh"

module lead_host_model (
    // Clock
    input  wire logic        pclk,
    // APB master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
    end

    // Entered just after a rising edge; returns one idle cycle later
    task automatic xfer(input logic w, input logic [9:0] idx,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released lines flip so a stale value can never look valid
        paddr   <= ~paddr;
        pwdata  <= ~pwdata;
        @(posedge pclk);
    endtask

    // Coupled pins need both enables set in the same access
    task automatic couple_sense(input logic on);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, `IDX_DC_CTRL, on ? 32'h60 : 32'h0, q, e);
    endtask
endmodule

// File: verification/electrode_lead_off_monitor_tb_top.sv
`include "leadoff_defines.svh"

module electrode_lead_off_monitor_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import leadoff_pkg::*;

    typedef struct packed {
        logic [9:0] idx;
        logic [7:0] wd;
        logic [7:0] rd;
        logic       err;
    } reg_t;
    typedef struct packed {
        logic       fast;
        logic [7:0] ctl;
        logic       ac_en;
        logic [6:0] mask;
        logic [5:0] pins;
        logic [7:0] adc;
        logic [7:0] cyc;
        logic [6:0] exp;
    } case_t;

    logic        pclk = 1'b0;
    logic        presetn;
    logic        psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        e;
    logic        exp_irq;
    cmp_pins_t   cmp_pins;
    adc_word_t   adc_word;
    cfg_t        cfg;
    int          errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    reg_t regs[9] = '{'{`IDX_MASK, 8'h7F, 8'h7F, 1'b0},
        '{`IDX_CLOCK, 8'h20, 8'h20, 1'b0}, '{`IDX_AC_CTRL, 8'h01, 8'h01, 1'b0},
        '{`IDX_AC_LOWER, 8'hA5, 8'hA5, 1'b0},
        '{`IDX_AC_UPPER, 8'h5A, 8'h5A, 1'b0},
        '{`IDX_DC_CTRL, 8'h77, 8'h77, 1'b0},
        '{`IDX_DC_THRESH, 8'h0F, 8'h0F, 1'b0},
        '{10'h3FF, 8'hFF, 8'h00, 1'b1}, '{`IDX_STATUS, 8'h00, 8'h00, 1'b0}};
    case_t cases[16] = '{
        '{1'b1, 8'h60, 1'b0, 7'h7F, 6'h20, 8'h40, 8'd16, 7'h00},
        '{1'b1, 8'h60, 1'b0, 7'h7F, 6'h20, 8'h40, 8'd26, 7'h08},
        '{1'b0, 8'h60, 1'b0, 7'h7F, 6'h20, 8'h40, 8'd26, 7'h00},
        '{1'b0, 8'h60, 1'b0, 7'h7F, 6'h20, 8'h40, 8'd40, 7'h08},
        '{1'b1, 8'h10, 1'b0, 7'h7F, 6'h04, 8'h40, 8'd40, 7'h00},
        '{1'b1, 8'h60, 1'b0, 7'h00, 6'h04, 8'h40, 8'd26, 7'h01},
        '{1'b1, 8'h10, 1'b0, 7'h7F, 6'h02, 8'h40, 8'd18, 7'h00},
        '{1'b1, 8'h10, 1'b0, 7'h7F, 6'h02, 8'h40, 8'd30, 7'h10},
        '{1'b0, 8'h10, 1'b0, 7'h7F, 6'h01, 8'h40, 8'd30, 7'h00},
        '{1'b0, 8'h10, 1'b0, 7'h7F, 6'h01, 8'h40, 8'd44, 7'h10},
        '{1'b1, 8'h00, 1'b0, 7'h7F, 6'h03, 8'h40, 8'd44, 7'h00},
        '{1'b1, 8'h00, 1'b1, 7'h7F, 6'h00, 8'h90, 8'd32, 7'h40},
        '{1'b1, 8'h00, 1'b1, 7'h7F, 6'h00, 8'h80, 8'd32, 7'h00},
        '{1'b1, 8'h00, 1'b1, 7'h7F, 6'h00, 8'h05, 8'd32, 7'h20},
        '{1'b1, 8'h00, 1'b1, 7'h7F, 6'h00, 8'h05, 8'd14, 7'h00},
        '{1'b1, 8'h00, 1'b0, 7'h7F, 6'h00, 8'h05, 8'd32, 7'h00}};

    always #10 pclk = ~pclk;

    electrode_lead_off_monitor #(.DC_FAST_CYC(20), .DC_SLOW_CYC(32),
        .DRV_FAST_CYC(24), .DRV_SLOW_CYC(36), .AC_CYC(22)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .cmp_pins(cmp_pins),
        .adc_word(adc_word), .cfg(cfg), .irq(irq));

    lead_host_model host (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr));

    task automatic chk(input logic [31:0] seen, input logic [31:0] expd);
        samples_checked = samples_checked + 1;
        if (seen !== expd) begin
            errors = errors + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expd);
        end
    endtask

    task automatic wr(input logic [9:0] i, input logic [31:0] d);
        host.xfer(1'b1, i, d, q, e);
    endtask

    task automatic rd(input logic [9:0] i);
        host.xfer(1'b0, i, 32'h0, q, e);
    endtask

    task automatic pulse(input logic [7:0] a);
        // Low bits are fixed at ABC, not zero, so that only the top byte may decide
        adc_word <= '{1'b1, {a, 12'hABC}};
        @(posedge pclk);
        adc_word.valid <= 1'b0;
    endtask

    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            tally_and_finish();
        end
    end

    initial begin
        presetn <= 1'b0;
        cmp_pins <= '0;
        adc_word <= '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        foreach (regs[i]) begin
            rd(regs[i].idx);
            chk({q[31:1], e}, {31'h0, regs[i].err});
            wr(regs[i].idx, {24'h0, regs[i].wd});
            rd(regs[i].idx);
            chk({q[31:1], e}, {24'h0, regs[i].rd[7:1], regs[i].err});
            chk({31'h0, q[0]}, {31'h0, regs[i].rd[0]});
        end
        chk({4'h0, cfg}, 32'hFFFA55A);
        wr(`IDX_AC_LOWER, 32'h10);
        wr(`IDX_AC_UPPER, 32'h80);
        $display("register test done");
        foreach (cases[i]) begin
            wr(`IDX_CLOCK, {26'h0, cases[i].fast, 5'h00});
            wr(`IDX_DC_CTRL, {24'h0, cases[i].ctl});
            wr(`IDX_AC_CTRL, {31'h0, cases[i].ac_en});
            wr(`IDX_MASK, {25'h0, cases[i].mask});
            cmp_pins <= cmp_pins_t'(cases[i].pins);
            pulse(cases[i].adc);
            repeat (cases[i].cyc) @(posedge pclk);
            cmp_pins <= '0;
            pulse(8'h40);
            repeat (8) @(posedge pclk);
            exp_irq = |(cases[i].exp & cases[i].mask);
            chk({31'h0, irq}, {31'h0, exp_irq});
            rd(`IDX_STATUS);
            chk(q, {25'h0, cases[i].exp});
            rd(`IDX_STATUS);
            chk(q, 32'h0);
            $display("case %0d done", i);
        end
        host.couple_sense(1'b1);
        cmp_pins <= cmp_pins_t'(6'h20);
        repeat (14) @(posedge pclk);
        host.couple_sense(1'b0);
        host.couple_sense(1'b1);
        repeat (12) @(posedge pclk);
        cmp_pins <= '0;
        repeat (8) @(posedge pclk);
        rd(`IDX_STATUS);
        chk(q, 32'h0);
        cmp_pins <= cmp_pins_t'(6'h20);
        repeat (26) @(posedge pclk);
        cmp_pins <= '0;
        repeat (8) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        wr(`IDX_STATUS, 32'h7F);
        chk({31'h0, irq}, 32'h0);
        rd(`IDX_STATUS);
        chk(q, 32'h0);
        $display("restart and clear tests done");
        // Reset in mid-run while a fault is flagged and still present
        cmp_pins <= cmp_pins_t'(6'h20);
        repeat (30) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({4'h0, cfg}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, pready}, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rd(`IDX_STATUS);
        chk(q, 32'h0);
        cmp_pins <= '0;
        $display("reset test done");
        tally_and_finish();
    end
endmodule
